// ### hdl/timer_compare_pwm.sv
// Sixteen-bit counter with clear-on-match and phase-correct PWM output
//
// Behaviour
// - Clear-on-match at /8 shows C one cycle, then zero six cycles.
// - Compare at top with undivided clock gives no PWM pulse at all.
// - Compare at top with divided clock: output goes active at top.
// - Down match then waits for the next top, giving one-period pulse.
`timescale 1ns/1ps

module timer_compare_pwm (
  input wire logic MCLK,
  input wire logic RST,
  input wire timer_pkg::counter_control_b_s COUNTER_CONTROL_B,
  input wire logic [15:0] COMPARE,
  input wire logic EXT_CLOCK,
  output logic [15:0] COUNT,
  output logic PWM_OUT,
  output logic MATCH,
  output logic OVERFLOW
);

  // ---------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------
  function automatic logic prescale_tick(
    input logic [2:0] cs,
    input logic [9:0] psc,
    input logic fall,
    input logic rise
  );
    logic t;
    begin
      t = 1'b0;
      case (cs)
        timer_pkg::CS_DIV1: t = 1'b1;
        timer_pkg::CS_DIV8: t = (psc[2:0] == 3'h7);
        timer_pkg::CS_DIV64: t = (psc[5:0] == 6'h3f);
        timer_pkg::CS_DIV256: t = (psc[7:0] == 8'hff);
        timer_pkg::CS_DIV1024: t = (psc == 10'h3ff);
        timer_pkg::CS_EXT_FALL: t = fall;
        timer_pkg::CS_EXT_RISE: t = rise;
        default: t = 1'b0;
      endcase
      prescale_tick = t;
    end
  endfunction

  function automatic logic [15:0] top_of(input logic [1:0] mode);
    logic [15:0] t;
    begin
      case (mode)
        timer_pkg::PWM_8BIT: t = timer_pkg::TOP_8BIT;
        timer_pkg::PWM_9BIT: t = timer_pkg::TOP_9BIT;
        timer_pkg::PWM_10BIT: t = timer_pkg::TOP_10BIT;
        default: t = timer_pkg::TOP_FREE;
      endcase
      top_of = t;
    end
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [9:0] psc;
  logic ext_prev;
  logic [15:0] count;
  timer_pkg::dir_e dir;
  logic pwm;
  logic down_armed;
  logic hit_pending;
  logic match;
  logic overflow;

  logic [2:0] cs;
  logic pwm_on;
  logic ctc;
  logic [15:0] top;
  logic tick;
  logic divided;
  logic clear_now;
  logic going_up;
  logic [15:0] next_count;
  logic top_compare;

  assign cs = COUNTER_CONTROL_B.counter_clock_select;
  assign pwm_on = (COUNTER_CONTROL_B.pwm_mode != timer_pkg::PWM_OFF);
  assign ctc = COUNTER_CONTROL_B.clear_on_match_bit && !pwm_on;
  assign top = top_of(COUNTER_CONTROL_B.pwm_mode);
  // Stop code yields no tick, so count, direction and PWM hold; the prescaler still runs
  assign tick = prescale_tick(cs, psc, ext_prev && !EXT_CLOCK,
                              !ext_prev && EXT_CLOCK);
  assign divided = (cs != timer_pkg::CS_DIV1) && (cs != timer_pkg::CS_STOP);
  // Clear lands one CPU cycle after the count first shows C
  // A stop drops a pending clear, so a held value never moves
  assign clear_now = ctc && hit_pending && (cs != timer_pkg::CS_STOP);
  assign going_up = (dir == timer_pkg::DIR_UP) && (count < top);
  assign top_compare = pwm_on && (COMPARE == top);

  always_comb begin
    next_count = count;
    if (!pwm_on) begin
      next_count = count + 16'h0001;
    end else if (going_up) begin
      next_count = count + 16'h0001;
    end else if (count != 16'h0000) begin
      next_count = count - 16'h0001;
    end else begin
      next_count = count + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  // Restarting the prescaler on a clear trims the zero run to div-2
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      psc <= timer_pkg::PSC_RESET;
    end else if (clear_now) begin
      psc <= timer_pkg::PSC_RELOAD;
    end else begin
      psc <= psc + 10'h001;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= EXT_CLOCK;
    end
  end

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      count <= timer_pkg::COUNT_RESET;
    end else if (clear_now) begin
      count <= timer_pkg::COUNT_RESET;
    end else if (tick) begin
      count <= next_count;
    end
  end

  // Marks the single cycle in which the count first equals the compare
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      hit_pending <= 1'b0;
    end else begin
      hit_pending <= tick && !clear_now && !pwm_on &&
                     (next_count == COMPARE);
    end
  end

  // Direction follows the next value, so the turn happens at top and zero
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      dir <= timer_pkg::DIR_UP;
    end else if (!pwm_on) begin
      dir <= timer_pkg::DIR_UP;
    end else if (tick) begin
      if (next_count >= top) begin
        dir <= timer_pkg::DIR_DOWN;
      end else if (next_count == 16'h0000) begin
        dir <= timer_pkg::DIR_UP;
      end
    end
  end

  // ---------------------------------------------------------------
  // PWM output
  // ---------------------------------------------------------------
  // Up match drives active, down match drives inactive
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pwm <= 1'b0;
      down_armed <= 1'b0;
    end else if (!pwm_on) begin
      pwm <= 1'b0;
      down_armed <= 1'b0;
    end else if (tick && top_compare && next_count == top) begin
      if (!divided) begin
        // Up and down match coincide and cancel
        pwm <= pwm;
        down_armed <= 1'b0;
      end else if (down_armed) begin
        // Delayed down match seen only at this next top
        pwm <= 1'b0;
        down_armed <= 1'b0;
      end else begin
        pwm <= 1'b1;
        down_armed <= 1'b1;
      end
    end else if (tick && !top_compare && next_count == COMPARE) begin
      pwm <= going_up;
    end
  end

  // ---------------------------------------------------------------
  // Event pulses
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      match <= 1'b0;
    end else begin
      match <= tick && !clear_now && (next_count == COMPARE);
    end
  end

  // Wrap in free running mode, bottom turn in PWM mode
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      overflow <= 1'b0;
    end else begin
      overflow <= tick && !clear_now &&
                  (pwm_on ? (next_count == 16'h0000)
                          : (count == timer_pkg::TOP_FREE));
    end
  end

  assign COUNT = count;
  assign PWM_OUT = pwm;
  assign MATCH = match;
  assign OVERFLOW = overflow;

endmodule // timer_compare_pwm

// ### shared/timer_pkg.sv
// Package: constants and types for the compare/PWM counter block
package timer_pkg;

  // ---------------------------------------------------------------
  // Clock select encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // ---------------------------------------------------------------
  // PWM resolution encodings and tops
  // ---------------------------------------------------------------
  localparam logic [1:0] PWM_OFF = 2'h0;
  localparam logic [1:0] PWM_8BIT = 2'h1;
  localparam logic [1:0] PWM_9BIT = 2'h2;
  localparam logic [1:0] PWM_10BIT = 2'h3;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] TOP_FREE = 16'hffff;

  // ---------------------------------------------------------------
  // Prescaler, reset values
  // ---------------------------------------------------------------
  localparam int PSC_WIDTH = 10;
  localparam logic [9:0] PSC_RESET = 10'h000;
  // Restart point after a clear so that a /8 period holds zero 6 cycles
  localparam logic [9:0] PSC_RELOAD = 10'h002;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } dir_e;

  typedef struct packed {
    logic [2:0] counter_clock_select;
    logic clear_on_match_bit;
    logic [1:0] pwm_mode;
  } counter_control_b_s;

endpackage

// ### verification/timer1_compare_pwm_corrections_tb.sv
// Testbench for the compare/PWM counter block
`timescale 1ns/1ps
module timer1_compare_pwm_corrections_tb;
  // ----
  // Stimulus
  // ----
  typedef struct {logic [2:0] cs; int zeros;} row_s;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  timer_pkg::counter_control_b_s ctl = '0;
  logic [15:0] cmp = 16'h0000;
  logic [15:0] count;
  logic pwm_out;
  logic match;
  logic ovf;
  int error_cnt = 0;
  int compares = 0;
  int n;
  row_s rows[5] = '{'{timer_pkg::CS_DIV1, 1}, '{timer_pkg::CS_DIV8, 6},
    '{timer_pkg::CS_DIV64, 62}, '{timer_pkg::CS_DIV256, 254},
    '{timer_pkg::CS_DIV1024, 1022}};
  always #20 mclk = ~mclk;
  timer_compare_pwm u_timer_compare_pwm (.MCLK(mclk), .RST(rst),
    .COUNTER_CONTROL_B(ctl), .COMPARE(cmp), .EXT_CLOCK(1'b0),
    .COUNT(count), .PWM_OUT(pwm_out), .MATCH(match), .OVERFLOW(ovf));
  task automatic finish_test();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h, want %0h", $time, got, exp);
    end
  endtask
  // Cycles while the output (pwm if sel) equals v, or differs if !same
  task automatic run(input logic [15:0] v, input bit sel, input bit same,
    output int k);
    k = 0;
    while (((sel ? {15'h0000, pwm_out} : count) === v) == same) begin
      @(negedge mclk);
      k++;
      if (k > 9000) begin
        error_cnt++;
        finish_test();
      end
    end
  endtask
  task automatic restart(input logic [2:0] cs, input logic clr,
    input logic [1:0] md, input logic [15:0] c);
    rst = 1'b1;
    repeat (8) @(negedge mclk);
    ctl = {cs, clr, md};
    cmp = c;
    rst = 1'b0;
  endtask
  initial begin
    foreach (rows[i]) begin
      restart(rows[i].cs, 1'b1, timer_pkg::PWM_OFF, 16'h0005);
      run(16'h0005, 1'b0, 1'b0, n);
      chk(match, 1'b1);
      run(16'h0005, 1'b0, 1'b1, n);
      chk(n, 1);
      run(16'h0000, 1'b0, 1'b1, n);
      chk(n, rows[i].zeros);
      chk(count, 16'h0001);
      chk(match, 1'b0);
    end
    restart(timer_pkg::CS_DIV1, 1'b0, timer_pkg::PWM_8BIT,
      timer_pkg::TOP_8BIT);
    run(timer_pkg::TOP_8BIT, 1'b0, 1'b0, n);
    n = 0;
    repeat (1100) begin
      @(negedge mclk);
      if (pwm_out !== 1'b0) n++;
    end
    chk(n, 0);
    restart(timer_pkg::CS_DIV8, 1'b0, timer_pkg::PWM_8BIT,
      timer_pkg::TOP_8BIT);
    run(timer_pkg::TOP_8BIT, 1'b0, 1'b0, n);
    run(16'h0001, 1'b1, 1'b0, n);
    chk(n, 0);
    // High and low both span a whole top-to-top period
    run(16'h0001, 1'b1, 1'b1, n);
    chk(n, 2 * timer_pkg::TOP_8BIT * 8);
    run(16'h0000, 1'b1, 1'b1, n);
    chk(n, 2 * timer_pkg::TOP_8BIT * 8);
    // Bottom turn gives a one-cycle overflow pulse
    run(16'h0000, 1'b0, 1'b0, n);
    chk(ovf, 1'b1);
    @(negedge mclk);
    chk(ovf, 1'b0);
    restart(timer_pkg::CS_DIV1, 1'b0, timer_pkg::PWM_8BIT, 16'h0003);
    run(16'h0014, 1'b0, 1'b0, n);
    ctl.counter_clock_select = timer_pkg::CS_STOP;
    repeat (50) @(negedge mclk);
    chk(count, 16'h0014);
    chk(pwm_out, 1'b1);
    rst = 1'b1;
    @(negedge mclk);
    chk(count, timer_pkg::COUNT_RESET);
    chk(pwm_out, 1'b0);
    finish_test();
  end
endmodule // timer1_compare_pwm_corrections_tb

// ### verification/timer_compare_pwm_chk.sv
// Assertions on the ports of the compare/PWM counter block
`timescale 1ns/1ps
module timer_compare_pwm_chk (
  input wire logic MCLK,
  input wire logic RST,
  input wire timer_pkg::counter_control_b_s COUNTER_CONTROL_B,
  input wire logic [15:0] COMPARE,
  input wire logic [15:0] COUNT,
  input wire logic PWM_OUT,
  input wire logic MATCH
);
  logic [2:0] cs;
  logic [1:0] md;
  logic [15:0] top;
  logic attop;
  logic div;
  assign cs = COUNTER_CONTROL_B.counter_clock_select;
  assign md = COUNTER_CONTROL_B.pwm_mode;
  assign top = md == timer_pkg::PWM_8BIT ? timer_pkg::TOP_8BIT :
    md == timer_pkg::PWM_9BIT ? timer_pkg::TOP_9BIT : timer_pkg::TOP_10BIT;
  assign attop = md != timer_pkg::PWM_OFF && COMPARE == top;
  // Stop is not a divided clock even though it is not undivided
  assign div = cs != timer_pkg::CS_DIV1 && cs != timer_pkg::CS_STOP;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  property p_clear;
    md == timer_pkg::PWM_OFF && COUNTER_CONTROL_B.clear_on_match_bit &&
    cs == timer_pkg::CS_DIV8 && MATCH |-> COUNT == COMPARE &&
    $past(COUNT) != COMPARE ##1 (COUNT == 16'h0000) [*6] ##1
    COUNT == 16'h0001;
  endproperty
  a_clear: assert property (p_clear) else $error("clear run wrong");
  property p_notop1;
    attop && cs == timer_pkg::CS_DIV1 |=> $stable(PWM_OUT);
  endproperty
  a_notop1: assert property (p_notop1) else $error("pwm moved");
  property p_rise;
    attop && div && COUNT == top && $past(COUNT) != top && !$past(PWM_OUT)
    |-> ##[0:1] PWM_OUT;
  endproperty
  a_rise: assert property (p_rise) else $error("pwm not set at top");
  property p_fall;
    attop && div && $fell(PWM_OUT) |-> COUNT == top;
  endproperty
  a_fall: assert property (p_fall) else $error("pwm cleared early");
  property p_hold;
    cs == timer_pkg::CS_STOP |=> $stable(COUNT) && $stable(PWM_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("stopped counter moved");
endmodule // timer_compare_pwm_chk
bind timer_compare_pwm timer_compare_pwm_chk u_timer_compare_pwm_chk (
  .MCLK(MCLK), .RST(RST), .COUNTER_CONTROL_B(COUNTER_CONTROL_B),
  .COMPARE(COMPARE), .COUNT(COUNT), .PWM_OUT(PWM_OUT), .MATCH(MATCH));
